// ===== delay_timer.sv
// One-shot cycle timer for sleep entry, wake and program cycles
`timescale 1ns/1ps
`default_nettype none
module delay_timer #(
  parameter int CNT_W = 20
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic reset_n,
  // Control
  delay_timer_if.timer tmr
);

  logic [CNT_W-1:0] remain_r;
  logic busy_r;
  logic done_r;

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      remain_r <= '0;
      busy_r <= 1'b0;
      done_r <= 1'b0;
    end else begin
      done_r <= 1'b0;
      if (tmr.start) begin
        remain_r <= tmr.cycles;
        busy_r <= 1'b1;
      end else if (busy_r) begin
        if (remain_r <= CNT_W'(1)) begin
          busy_r <= 1'b0;
          done_r <= 1'b1;
        end else begin
          remain_r <= remain_r - CNT_W'(1);
        end
      end
    end
  end

  assign tmr.busy = busy_r;
  assign tmr.done = done_r;

endmodule : delay_timer
`default_nettype wire

// ===== delay_timer_if.sv
// Start/done link between the command block and its delay timer
`timescale 1ns/1ps
`default_nettype none
interface delay_timer_if #(parameter int CNT_W = 20);
  logic start;
  logic [CNT_W-1:0] cycles;
  logic busy;
  logic done;
  modport ctrl (output start, output cycles, input busy, input done);
  modport timer (input start, input cycles, output busy, output done);
endinterface : delay_timer_if
`default_nettype wire

// ===== flash_cmd_pkg.sv
// Constants shared by the serial flash command block
package flash_cmd_pkg;

  // Opcodes
  localparam logic [7:0] OP_WRITE_LATCH_SET = 8'h06;
  localparam logic [7:0] OP_STATUS_WRITE = 8'h01;
  localparam logic [7:0] OP_QUAD_PAGE_PROGRAM = 8'h38;
  localparam logic [7:0] OP_DEEP_SLEEP = 8'hB9;
  localparam logic [7:0] OP_WAKE_SIGNATURE = 8'hAB;
  localparam logic [7:0] OP_MAKER_PART_READ = 8'h90;
  localparam logic [7:0] OP_QUAD_IDENT_READ = 8'hAF;
  localparam logic [7:0] OP_OTP_ENTER = 8'hB1;
  localparam logic [7:0] OP_OTP_EXIT = 8'hC1;
  localparam logic [7:0] OP_SEC_STATUS_READ = 8'h2B;
  localparam logic [7:0] OP_SEC_STATUS_WRITE = 8'h2F;
  localparam logic [7:0] OP_SOFT_RESET = 8'h99;

  // Security status register bit positions
  localparam int SEC_FACTORY_LOCK = 0;
  localparam int SEC_OTP_LOCKDOWN = 1;
  localparam int SEC_PROGRAM_PAUSED = 2;
  localparam int SEC_ERASE_PAUSED = 3;
  localparam int SEC_RESERVED = 4;
  localparam int SEC_PROGRAM_FAIL = 5;
  localparam int SEC_ERASE_FAIL = 6;
  localparam int SEC_PROTECT_SCHEME = 7;
  localparam logic [7:0] SEC_RESET = 8'h00;

  // Identity bytes, values arbitrary
  localparam logic [7:0] ID_MAKER = 8'h5A;
  localparam logic [7:0] ID_MEM_TYPE = 8'h6B;
  localparam logic [7:0] ID_DEVICE = 8'h7C;

  // Header lengths in bytes, opcode included; then the device-first ID address and the page size
  localparam logic [9:0] HDR_SHORT = 10'h001;
  localparam logic [9:0] HDR_MAKER_PART = 10'h004;
  localparam logic [9:0] HDR_PROGRAM = 10'h004;
  localparam logic [7:0] ADDR_DEVICE_FIRST = 8'h01;
  localparam logic [8:0] PAGE_BYTES = 9'h100;

  // Timing
  localparam int CLK_NS = 4;
  localparam int SLEEP_ENTRY_NS = 3000;
  localparam int WAKE_NS = 30000;
  localparam int PROGRAM_NS = 1000000;
  localparam int SLEEP_ENTRY_CYC = (SLEEP_ENTRY_NS + CLK_NS - 1) / CLK_NS;
  localparam int WAKE_CYC = (WAKE_NS + CLK_NS - 1) / CLK_NS;
  localparam int PROGRAM_CYC = (PROGRAM_NS + CLK_NS - 1) / CLK_NS;
  localparam int TIMER_W = 20;

  // Power states, Gray along standby-entering-sleep-waking
  typedef enum logic [1:0] {
    PWR_STANDBY = 2'b00,
    PWR_ENTERING = 2'b01,
    PWR_SLEEP = 2'b11,
    PWR_WAKING = 2'b10
  } power_e;

endpackage : flash_cmd_pkg

// ===== flash_host_model.sv
// Host controller model driving the serial link
`timescale 1ns/1ps
`default_nettype none
module flash_host_model (
  // Link pins
  output logic serialClk,
  output logic chipSelectN,
  output logic [3:0] quadIoIn,
  input wire logic [3:0] quadIoOut
);
  logic [7:0] rxByte;
  event rxEv;
  initial begin
    serialClk = 1'b0;
    chipSelectN = 1'b1;
    quadIoIn = 4'h0;
  end
  ////////////////////////////////////////////////////////////
  // 48 ns period, clock still outside frames
  task automatic clk1();
    #24 serialClk = 1'b1;
    #24 serialClk = 1'b0;
  endtask : clk1
  task automatic sel();
    #24 chipSelectN = 1'b0;
  endtask : sel
  // Released lanes flip so stale data never looks valid
  task automatic desel();
    #24 chipSelectN = 1'b1;
    quadIoIn = ~quadIoIn;
  endtask : desel
  task automatic put(input logic [7:0] b, input bit q);
    for (int i = 0; i < (q ? 2 : 8); i++) begin
      quadIoIn = q ? (i == 0 ? b[7:4] : b[3:0]) : {~quadIoIn[3:1], b[7-i]};
      clk1();
    end
  endtask : put
  task automatic get(input bit q);
    logic [7:0] v;
    v = 8'h00;
    for (int i = 0; i < (q ? 2 : 8); i++) begin
      #24 serialClk = 1'b1;
      v = q ? {v[3:0], quadIoOut} : {v[6:0], quadIoOut[1]};
      #24 serialClk = 1'b0;
    end
    rxByte = v;
    ->rxEv;
  endtask : get
endmodule : flash_host_model
`default_nettype wire

// ===== flash_power_id_otp_commands.sv
// Command interpreter for quad program, deep sleep, identification and OTP access
`timescale 1ns/1ps
`default_nettype none
module flash_power_id_otp_commands #(
  parameter int PROGRAM_CYCLES = flash_cmd_pkg::PROGRAM_CYC,
  parameter int SLEEP_CYCLES = flash_cmd_pkg::SLEEP_ENTRY_CYC,
  parameter int WAKE_CYCLES = flash_cmd_pkg::WAKE_CYC
) (
  // System clock and reset
  input wire logic sys_clk,
  input wire logic reset_n,
  // Serial link pins
  input wire logic serialClk,
  input wire logic chipSelectN,
  input wire logic [3:0] quadIoIn,
  output logic [3:0] quadIoOut,
  output logic [3:0] quadIoOeN,
  // Configuration from neighbouring device logic
  input wire logic quadIoEnable,
  input wire logic quadCmdMode,
  input wire logic eraseFailed,
  input wire logic programFailed,
  input wire logic erasePaused,
  input wire logic programPaused,
  // Non-volatile bits sampled after reset
  input wire logic nvFactoryLock,
  input wire logic nvProtectScheme,
  input wire logic nvOtpLockdown,
  // Status
  output logic [7:0] secStatus,
  output logic writeLatch,
  output logic writeInProgress,
  output logic deepSleep,
  output logic otpMode,
  // Array side
  output logic programStart,
  output logic programToOtp,
  output logic [23:0] programAddr,
  output logic [8:0] programLen,
  input wire logic [7:0] pageRdAddr,
  output logic [7:0] pageRdData,
  output logic lockdownBurn,
  output logic statusWriteGo
);

  ////////////////////////////////////////////////////////////////////////////
  // Link domain: levels from the system side, one flag per bit
  logic [11:0] lvlSys;
  logic [11:0] lvlMeta_r;
  logic [11:0] lvlSync_r;
  logic [7:0] secS;
  logic wipS;
  logic sleepS;
  logic qpiS;
  logic qeS;

  assign lvlSys = {secStatus, writeInProgress, deepSleep, quadCmdMode, quadIoEnable};

  always_ff @(posedge serialClk) begin
    lvlMeta_r <= lvlSys;
    lvlSync_r <= lvlMeta_r;
  end

  assign {secS, wipS, sleepS, qpiS, qeS} = lvlSync_r;

  ////////////////////////////////////////////////////////////////////////////
  // Link domain: input shifting on rising edges, restarted on the first edge after deselect
  logic [7:0] acc_r;
  logic [3:0] bitCnt_r;
  logic [9:0] byteIdx_r;
  logic [7:0] opcode_r;
  logic [23:0] addr_r;
  logic [8:0] dataCnt_r;
  logic [7:0] wrPtr_r;
  logic [7:0] pageBuf [0:255];
  logic lanes4;
  logic [3:0] bitsNxt;
  logic [7:0] accNxt;
  logic byteDone;
  logic fresh_r;
  logic [3:0] bitBase;
  logic [9:0] idxBase;
  logic [8:0] cntBase;

  assign bitBase = fresh_r ? 4'h0 : bitCnt_r;
  assign idxBase = fresh_r ? 10'h000 : byteIdx_r;
  assign cntBase = fresh_r ? 9'h000 : dataCnt_r;

  // Single-lane opcode ignores lanes 3..1; quad program data uses all four
  assign lanes4 = qpiS ||
                  (idxBase != 10'h000 && opcode_r == flash_cmd_pkg::OP_QUAD_PAGE_PROGRAM);
  assign bitsNxt = bitBase + (lanes4 ? 4'h4 : 4'h1);
  assign accNxt = lanes4 ? {acc_r[3:0], quadIoIn} : {acc_r[6:0], quadIoIn[0]};
  assign byteDone = (bitsNxt == 4'h8);

  // Deselect only arms a fresh start, so the system side can still read the frame
  // A select with no clocks at all replays the last frame
  always_ff @(posedge serialClk or posedge chipSelectN) begin
    if (chipSelectN) begin
      fresh_r <= 1'b1;
    end else begin
      fresh_r <= 1'b0;
    end
  end

  always_ff @(posedge serialClk) begin
    acc_r <= accNxt;
    bitCnt_r <= byteDone ? 4'h0 : bitsNxt;
    byteIdx_r <= idxBase;
    dataCnt_r <= cntBase;
    if (byteDone) begin
      if (idxBase != 10'h3FF) begin
        byteIdx_r <= idxBase + 10'h001;
      end
      if (idxBase == 10'h000) begin
        opcode_r <= accNxt;
      end else if (idxBase < flash_cmd_pkg::HDR_PROGRAM) begin
        addr_r <= {addr_r[15:0], accNxt};
        wrPtr_r <= accNxt;
      end else if (opcode_r == flash_cmd_pkg::OP_QUAD_PAGE_PROGRAM) begin
        wrPtr_r <= wrPtr_r + 8'h01;
        if (cntBase != flash_cmd_pkg::PAGE_BYTES) begin
          dataCnt_r <= cntBase + 9'h001;
        end
      end
    end
  end

  // Buffer frozen while a cycle runs, so a frame sent during the cycle cannot corrupt it
  always_ff @(posedge serialClk) begin
    if (!chipSelectN && byteDone && !wipS && byteIdx_r >= flash_cmd_pkg::HDR_PROGRAM &&
        opcode_r == flash_cmd_pkg::OP_QUAD_PAGE_PROGRAM) begin
      pageBuf[wrPtr_r] <= accNxt;
    end
  end

  assign pageRdData = pageBuf[pageRdAddr];

  ////////////////////////////////////////////////////////////////////////////
  // Link domain: output on falling edges
  logic rdSig;
  logic rdMakerPart;
  logic rdIdent;
  logic rdSec;
  logic txGo;
  logic [7:0] curByte;
  logic [2:0] txBit_r;
  logic [1:0] txSel_r;
  logic [3:0] ioOut_r;
  logic drive_r;

  assign rdSig = opcode_r == flash_cmd_pkg::OP_WAKE_SIGNATURE && !qpiS;
  assign rdMakerPart = opcode_r == flash_cmd_pkg::OP_MAKER_PART_READ && !qpiS && !sleepS;
  assign rdIdent = opcode_r == flash_cmd_pkg::OP_QUAD_IDENT_READ && qpiS && !sleepS;
  assign rdSec = opcode_r == flash_cmd_pkg::OP_SEC_STATUS_READ && !sleepS;
  assign txGo = ((rdSig || rdIdent || rdSec) && byteIdx_r >= flash_cmd_pkg::HDR_SHORT) ||
                (rdMakerPart && byteIdx_r >= flash_cmd_pkg::HDR_MAKER_PART);

  always_comb begin
    curByte = secS;
    if (rdSig) begin
      curByte = flash_cmd_pkg::ID_DEVICE;
    end else if (rdMakerPart) begin
      curByte = (txSel_r[0] ^ (addr_r[7:0] == flash_cmd_pkg::ADDR_DEVICE_FIRST)) ?
                flash_cmd_pkg::ID_DEVICE : flash_cmd_pkg::ID_MAKER;
    end else if (rdIdent) begin
      curByte = (txSel_r == 2'h0) ? flash_cmd_pkg::ID_MAKER :
                (txSel_r == 2'h1) ? flash_cmd_pkg::ID_MEM_TYPE : flash_cmd_pkg::ID_DEVICE;
    end
  end

  always_ff @(negedge serialClk or posedge chipSelectN) begin
    if (chipSelectN) begin
      txBit_r <= 3'h0;
      txSel_r <= 2'h0;
      ioOut_r <= 4'h0;
      drive_r <= 1'b0;
    end else if (txGo) begin
      drive_r <= 1'b1;
      if (qpiS) begin
        ioOut_r <= txBit_r[2] ? curByte[3:0] : curByte[7:4];
        txBit_r <= txBit_r + 3'h4;
      end else begin
        ioOut_r <= {2'b00, curByte[3'h7 - txBit_r], 1'b0};
        txBit_r <= txBit_r + 3'h1;
      end
      if ((qpiS && txBit_r == 3'h4) || (!qpiS && txBit_r == 3'h7)) begin
        if (rdMakerPart) begin
          txSel_r <= txSel_r ^ 2'h1;
        end else if (rdIdent) begin
          txSel_r <= (txSel_r == 2'h2) ? 2'h0 : txSel_r + 2'h1;
        end
      end
    end
  end

  assign quadIoOut = ioOut_r;
  assign quadIoOeN = !drive_r ? 4'hF : (qpiS ? 4'h0 : 4'hD);

  ////////////////////////////////////////////////////////////////////////////
  // System domain: deselect detection; frame fields are frozen while select is high
  logic csMeta_r;
  logic csSync_r;
  logic csPrev_r;
  logic csRise;
  logic onBoundary;
  logic awake;

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      csMeta_r <= 1'b1;
      csSync_r <= 1'b1;
      csPrev_r <= 1'b1;
    end else begin
      csMeta_r <= chipSelectN;
      csSync_r <= csMeta_r;
      csPrev_r <= csSync_r;
    end
  end

  assign csRise = csSync_r && !csPrev_r;
  assign onBoundary = bitCnt_r == 4'h0;

  ////////////////////////////////////////////////////////////////////////////
  // System domain: power, write latch, program cycle and OTP mode
  delay_timer_if #(.CNT_W(flash_cmd_pkg::TIMER_W)) tmrBus ();

  delay_timer #(.CNT_W(flash_cmd_pkg::TIMER_W)) u_timer (
    .sys_clk(sys_clk),
    .reset_n(reset_n),
    .tmr(tmrBus.timer)
  );

  flash_cmd_pkg::power_e power_r;
  logic wel_r;
  logic wip_r;
  logic otp_r;
  logic lockdown_r;
  logic factory_r;
  logic scheme_r;
  logic strapDone_r;
  logic isOp1;
  logic [7:0] op;

  assign op = opcode_r;
  assign awake = power_r == flash_cmd_pkg::PWR_STANDBY;
  assign isOp1 = onBoundary && byteIdx_r == flash_cmd_pkg::HDR_SHORT;

  always_comb begin
    tmrBus.start = 1'b0;
    tmrBus.cycles = flash_cmd_pkg::TIMER_W'(PROGRAM_CYCLES);
    if (csRise && awake && !wip_r && isOp1 && op == flash_cmd_pkg::OP_DEEP_SLEEP) begin
      tmrBus.start = 1'b1;
      tmrBus.cycles = flash_cmd_pkg::TIMER_W'(SLEEP_CYCLES);
    end else if (csRise && power_r == flash_cmd_pkg::PWR_SLEEP &&
                 op == flash_cmd_pkg::OP_WAKE_SIGNATURE && byteIdx_r != 10'h000) begin
      tmrBus.start = 1'b1;
      tmrBus.cycles = flash_cmd_pkg::TIMER_W'(WAKE_CYCLES);
    end else if (csRise && awake && programStart) begin
      tmrBus.start = 1'b1;
    end
  end

  // Program accepted only on a whole byte with at least one data byte
  always_comb begin
    programStart = csRise && awake && wel_r && quadIoEnable && !wip_r && onBoundary &&
                   op == flash_cmd_pkg::OP_QUAD_PAGE_PROGRAM && dataCnt_r != 9'h000 &&
                   !(otp_r && lockdown_r);
  end

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      power_r <= flash_cmd_pkg::PWR_STANDBY;
    end else if (csRise && op == flash_cmd_pkg::OP_SOFT_RESET && isOp1 && !wip_r) begin
      power_r <= flash_cmd_pkg::PWR_STANDBY;
    end else if (csRise && op == flash_cmd_pkg::OP_WAKE_SIGNATURE && byteIdx_r != 10'h000) begin
      unique case (power_r)
        flash_cmd_pkg::PWR_SLEEP: power_r <= flash_cmd_pkg::PWR_WAKING;
        flash_cmd_pkg::PWR_ENTERING: power_r <= flash_cmd_pkg::PWR_STANDBY;
        flash_cmd_pkg::PWR_STANDBY: power_r <= flash_cmd_pkg::PWR_STANDBY;
        flash_cmd_pkg::PWR_WAKING: power_r <= flash_cmd_pkg::PWR_WAKING;
      endcase
    end else if (csRise && awake && !wip_r && isOp1 && op == flash_cmd_pkg::OP_DEEP_SLEEP) begin
      power_r <= flash_cmd_pkg::PWR_ENTERING;
    end else if (tmrBus.done && !wip_r) begin
      unique case (power_r)
        flash_cmd_pkg::PWR_ENTERING: power_r <= flash_cmd_pkg::PWR_SLEEP;
        flash_cmd_pkg::PWR_WAKING: power_r <= flash_cmd_pkg::PWR_STANDBY;
        flash_cmd_pkg::PWR_SLEEP: power_r <= flash_cmd_pkg::PWR_SLEEP;
        flash_cmd_pkg::PWR_STANDBY: power_r <= flash_cmd_pkg::PWR_STANDBY;
      endcase
    end
  end

  // Write latch: cleared at end of program cycle, by reset and by security write
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      wel_r <= 1'b0;
    end else if (wip_r && tmrBus.done) begin
      wel_r <= 1'b0;
    end else if (csRise && isOp1 && (op == flash_cmd_pkg::OP_SOFT_RESET ||
                 (op == flash_cmd_pkg::OP_SEC_STATUS_WRITE && awake && wel_r && !otp_r))) begin
      wel_r <= 1'b0;
    end else if (csRise && awake && !wip_r && isOp1 && op == flash_cmd_pkg::OP_WRITE_LATCH_SET) begin
      wel_r <= 1'b1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      wip_r <= 1'b0;
    end else if (programStart) begin
      wip_r <= 1'b1;
    end else if (tmrBus.done) begin
      wip_r <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      otp_r <= 1'b0;
    end else if (csRise && awake && isOp1) begin
      if (op == flash_cmd_pkg::OP_OTP_ENTER) begin
        otp_r <= 1'b1;
      end else if (op == flash_cmd_pkg::OP_OTP_EXIT || op == flash_cmd_pkg::OP_SOFT_RESET) begin
        otp_r <= 1'b0;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      programAddr <= 24'h000000;
      programLen <= 9'h000;
      programToOtp <= 1'b0;
    end else if (programStart) begin
      programAddr <= addr_r;
      programLen <= dataCnt_r;
      programToOtp <= otp_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // System domain: security status register
  // Straps taken by a clocked process on the first edge after release
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      strapDone_r <= 1'b0;
      factory_r <= 1'b0;
      scheme_r <= 1'b0;
      lockdown_r <= 1'b0;
      lockdownBurn <= 1'b0;
      statusWriteGo <= 1'b0;
    end else begin
      lockdownBurn <= 1'b0;
      statusWriteGo <= 1'b0;
      if (!strapDone_r) begin
        strapDone_r <= 1'b1;
        factory_r <= nvFactoryLock;
        scheme_r <= nvProtectScheme;
        lockdown_r <= nvOtpLockdown;
      end else if (csRise && awake && isOp1 && wel_r && !otp_r &&
                   op == flash_cmd_pkg::OP_SEC_STATUS_WRITE) begin
        lockdown_r <= 1'b1;
        lockdownBurn <= !lockdown_r;
      end
      if (csRise && awake && wel_r && !wip_r && !otp_r && onBoundary &&
          op == flash_cmd_pkg::OP_STATUS_WRITE && byteIdx_r > flash_cmd_pkg::HDR_SHORT) begin
        statusWriteGo <= 1'b1;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      secStatus <= flash_cmd_pkg::SEC_RESET;
    end else begin
      secStatus[flash_cmd_pkg::SEC_PROTECT_SCHEME] <= scheme_r;
      secStatus[flash_cmd_pkg::SEC_ERASE_FAIL] <= eraseFailed;
      secStatus[flash_cmd_pkg::SEC_PROGRAM_FAIL] <= programFailed;
      secStatus[flash_cmd_pkg::SEC_RESERVED] <= 1'b0;
      secStatus[flash_cmd_pkg::SEC_ERASE_PAUSED] <= erasePaused;
      secStatus[flash_cmd_pkg::SEC_PROGRAM_PAUSED] <= programPaused;
      secStatus[flash_cmd_pkg::SEC_OTP_LOCKDOWN] <= lockdown_r;
      secStatus[flash_cmd_pkg::SEC_FACTORY_LOCK] <= factory_r;
    end
  end

  assign writeLatch = wel_r;
  assign writeInProgress = wip_r;
  assign deepSleep = power_r == flash_cmd_pkg::PWR_SLEEP;
  assign otpMode = otp_r;

endmodule : flash_power_id_otp_commands
`default_nettype wire

// ===== flash_power_id_otp_commands_assertions.sv
// Port checker for the flash command block
`timescale 1ns/1ps
`default_nettype none
module flash_power_id_otp_commands_assertions #(
  parameter int PROGRAM_CYCLES = 20
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic reset_n,
  // Inputs watched
  input wire logic chipSelectN,
  input wire logic quadIoEnable,
  input wire logic eraseFailed,
  input wire logic programFailed,
  input wire logic erasePaused,
  input wire logic programPaused,
  // Outputs watched
  input wire logic [3:0] quadIoOeN,
  input wire logic [7:0] secStatus,
  input wire logic writeLatch,
  input wire logic writeInProgress,
  input wire logic deepSleep,
  input wire logic otpMode,
  input wire logic programStart,
  input wire logic [8:0] programLen,
  input wire logic lockdownBurn
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  logic [31:0] busyCnt_r;
  always_ff @(posedge sys_clk) begin
    if (!reset_n || !writeInProgress) busyCnt_r <= 32'h0;
    else busyCnt_r <= busyCnt_r + 32'h1;
  end
  ////////////////////////////////////////////////////////////
  idle_float_a: assert property (chipSelectN [*3] |-> quadIoOeN == 4'hF)
    else $error("lanes driven while deselected");
  prog_gate_a: assert property (programStart |-> writeLatch && quadIoEnable && !writeInProgress)
    else $error("program accepted without latch or enable");
  prog_busy_a: assert property (programStart |=> writeInProgress && programLen inside {[9'h001:9'h100]})
    else $error("program did not start busy");
  busy_time_a: assert property ($fell(writeInProgress) |-> !writeLatch && $past(busyCnt_r) >= PROGRAM_CYCLES - 2 && $past(busyCnt_r) <= PROGRAM_CYCLES + 4)
    else $error("program cycle length or latch wrong");
  reserved_zero_a: assert property (secStatus[4] == 1'b0)
    else $error("reserved status bit set");
  flag_copy_a: assert property ($past(reset_n, 3) |-> {secStatus[6:5], secStatus[3:2]} == $past({eraseFailed, programFailed, erasePaused, programPaused}))
    else $error("status flags not copied");
  lockdown_hold_a: assert property ($past(secStatus[1]) && $past(reset_n) |-> secStatus[1])
    else $error("lockdown flag cleared");
  sleep_quiet_a: assert property (deepSleep |-> !programStart && !$rose(writeLatch))
    else $error("write obeyed while asleep");
  lock_burn_a: assert property (lockdownBurn |-> !secStatus[1] ##1 secStatus[1])
    else $error("lockdown burn without a fresh lockdown");
  prog_c: cover property (programStart);
  sleep_c: cover property ($rose(deepSleep));
  otp_c: cover property ($rose(otpMode));
endmodule : flash_power_id_otp_commands_assertions
`default_nettype wire

// ===== flash_power_id_otp_commands_tb.sv
// Self-checking bench for the flash command block
`timescale 1ns/1ps
`default_nettype none
module flash_power_id_otp_commands_tb;
  localparam int PROG = 20;
  logic sys_clk = 1'b0;
  logic reset_n = 1'b0;
  logic serialClk, chipSelectN, quadIoEnable, quadCmdMode, eraseFailed, programFailed;
  logic erasePaused, programPaused, nvFactoryLock, nvProtectScheme, nvOtpLockdown;
  logic writeLatch, writeInProgress, deepSleep, otpMode, programStart, programToOtp;
  logic lockdownBurn, statusWriteGo;
  logic [3:0] quadIoIn, quadIoOut, quadIoOeN;
  logic [7:0] secStatus, pageRdAddr, pageRdData, stExp, base;
  logic [23:0] programAddr;
  logic [8:0] programLen;
  logic [31:0] seed;
  logic [7:0] expQ[$];
  int err_count = 0;
  int total_checks = 0;
  always #2 sys_clk = ~sys_clk;
  flash_power_id_otp_commands #(.PROGRAM_CYCLES(PROG), .SLEEP_CYCLES(5), .WAKE_CYCLES(8))
    DUT (.sys_clk, .reset_n, .serialClk, .chipSelectN, .quadIoIn, .quadIoOut, .quadIoOeN,
    .quadIoEnable, .quadCmdMode, .eraseFailed, .programFailed, .erasePaused, .programPaused,
    .nvFactoryLock, .nvProtectScheme, .nvOtpLockdown, .secStatus, .writeLatch, .writeInProgress,
    .deepSleep, .otpMode, .programStart, .programToOtp, .programAddr, .programLen, .pageRdAddr,
    .pageRdData, .lockdownBurn, .statusWriteGo);
  flash_host_model host (.serialClk, .chipSelectN, .quadIoIn, .quadIoOut);
  ////////////////////////////////////////////////////////////
  function automatic logic [31:0] xs(input logic [31:0] x);
    x = x ^ (x << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction : xs
  task automatic chk(input string nm, input logic [23:0] e, input logic [23:0] g);
    total_checks++;
    if (g !== e) begin
      err_count++;
      $display("MISMATCH %s expected %0h seen %0h", nm, e, g);
    end
  endtask : chk
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : tally_and_finish
  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask : cyc
  task automatic waitv(input string nm, ref logic s, input logic v, input int lim);
    int k;
    k = 0;
    while (s !== v && k < lim) begin
      cyc(1);
      k++;
    end
    chk(nm, 24'(v), 24'(s));
    if (s !== v) tally_and_finish();
  endtask : waitv
  task automatic cmd(input logic [7:0] op);
    host.sel();
    host.put(op, 1'b0);
    host.desel();
    cyc(8);
  endtask : cmd
  task automatic rd(input logic [7:0] e, input bit q);
    expQ.push_back(e);
    host.get(q);
  endtask : rd
  always @(host.rxEv) chk("read byte", 24'(expQ.pop_front()), 24'(host.rxByte));
  initial begin
    cyc(90000);
    err_count++;
    tally_and_finish();
  end
  initial begin
    seed = xs(32'hDAF7);
    {nvProtectScheme, eraseFailed, programFailed, erasePaused, programPaused, nvOtpLockdown,
      nvFactoryLock} = seed[6:0];
    stExp = {seed[6:4], 1'b0, seed[3:0]};
    base = seed[15:8];
    quadIoEnable = 1'b0;
    quadCmdMode = 1'b0;
    pageRdAddr = base;
    cyc(10);
    reset_n <= 1'b1;
    cyc(6);
    chk("status", 24'(stExp), 24'(secStatus));
    // Dummy frame fills the link level synchronisers
    cmd(8'h00);
    host.sel();
    host.put(8'h2B, 1'b0);
    rd(stExp, 1'b0);
    rd(stExp, 1'b0);
    host.desel();
    cyc(8);
    for (int a = 0; a < 2; a++) begin
      host.sel();
      host.put(8'h90, 1'b0);
      host.put(seed[23:16], 1'b0);
      host.put(seed[31:24], 1'b0);
      host.put(8'(a), 1'b0);
      for (int n = 0; n < 3; n++) begin
        rd(((n + a) % 2) ? flash_cmd_pkg::ID_DEVICE : flash_cmd_pkg::ID_MAKER, 1'b0);
      end
      host.desel();
      cyc(8);
    end
    $display("test ident done");
    host.sel();
    host.put(8'hB9, 1'b0);
    host.clk1();
    host.desel();
    cyc(20);
    chk("ragged sleep", 24'h0, 24'(deepSleep));
    cmd(8'hB9);
    waitv("sleep entry", deepSleep, 1'b1, 20);
    cmd(flash_cmd_pkg::OP_WRITE_LATCH_SET);
    chk("latch asleep", 24'h0, 24'(writeLatch));
    host.sel();
    host.put(8'hAB, 1'b0);
    rd(flash_cmd_pkg::ID_DEVICE, 1'b0);
    rd(flash_cmd_pkg::ID_DEVICE, 1'b0);
    host.desel();
    waitv("wake", deepSleep, 1'b0, 8);
    // Stay deselected through the whole wake delay
    cyc(14);
    $display("test power done");
    cmd(flash_cmd_pkg::OP_WRITE_LATCH_SET);
    prog(1);
    cyc(30);
    chk("refused program", 24'h0, 24'(writeInProgress));
    @(posedge sys_clk);
    quadIoEnable <= 1'b1;
    // Dummy frame lets the link pick up the enable
    cmd(8'h00);
    prog(257);
    waitv("program start", programStart, 1'b1, 12);
    cyc(1);
    chk("address", {16'h1234, base}, programAddr);
    chk("to otp", 24'h0, 24'(programToOtp));
    chk("length", 24'h100, 24'(programLen));
    chk("page wrap", 24'h01, 24'(pageRdData));
    chk("busy", 24'h1, 24'(writeInProgress));
    waitv("program end", writeInProgress, 1'b0, PROG + 8);
    chk("latch cleared", 24'h0, 24'(writeLatch));
    $display("test program done");
    cmd(flash_cmd_pkg::OP_OTP_ENTER);
    chk("otp enter", 24'h1, 24'(otpMode));
    cmd(flash_cmd_pkg::OP_WRITE_LATCH_SET);
    cmd(flash_cmd_pkg::OP_SEC_STATUS_WRITE);
    chk("lockdown refused", 24'(seed[1]), 24'(secStatus[1]));
    cmd(flash_cmd_pkg::OP_OTP_EXIT);
    chk("otp exit", 24'h0, 24'(otpMode));
    cmd(flash_cmd_pkg::OP_WRITE_LATCH_SET);
    cmd(flash_cmd_pkg::OP_SEC_STATUS_WRITE);
    chk("lockdown set", 24'h1, 24'(secStatus[1]));
    cmd(flash_cmd_pkg::OP_WRITE_LATCH_SET);
    host.sel();
    host.put(flash_cmd_pkg::OP_STATUS_WRITE, 1'b0);
    host.put(seed[7:0], 1'b0);
    host.desel();
    waitv("status write", statusWriteGo, 1'b1, 8);
    cyc(8);
    $display("test otp done");
    @(posedge sys_clk);
    quadCmdMode <= 1'b1;
    cmd(8'h00);
    host.sel();
    host.put(flash_cmd_pkg::OP_QUAD_IDENT_READ, 1'b1);
    rd(flash_cmd_pkg::ID_MAKER, 1'b1);
    rd(flash_cmd_pkg::ID_MEM_TYPE, 1'b1);
    rd(flash_cmd_pkg::ID_DEVICE, 1'b1);
    rd(flash_cmd_pkg::ID_MAKER, 1'b1);
    host.desel();
    cyc(8);
    $display("test quad done");
    tally_and_finish();
  end
  task automatic prog(input int n);
    host.sel();
    host.put(flash_cmd_pkg::OP_QUAD_PAGE_PROGRAM, 1'b0);
    host.put(8'h12, 1'b1);
    host.put(8'h34, 1'b1);
    host.put(base, 1'b1);
    for (int i = 0; i < n; i++) host.put(8'(i + i / 256), 1'b1);
    host.desel();
  endtask : prog
endmodule : flash_power_id_otp_commands_tb
bind flash_power_id_otp_commands flash_power_id_otp_commands_assertions
  #(.PROGRAM_CYCLES(PROGRAM_CYCLES)) chk (.sys_clk, .reset_n, .chipSelectN, .quadIoEnable,
  .eraseFailed, .programFailed, .erasePaused, .programPaused, .quadIoOeN, .secStatus,
  .writeLatch, .writeInProgress, .deepSleep, .otpMode, .programStart, .programLen, .lockdownBurn);
`default_nettype wire
